// *** logic/tcb_defs.svh ***
// Register offsets, field positions and reset values of the timer clock/clear block.
`ifndef TCB_DEFS_SVH
`define TCB_DEFS_SVH

// Word indexes on the internal 16-bit register bus.
`define TCB_OFF_CTRL0     6'h00
`define TCB_OFF_CNT0      6'h05
`define TCB_OFF_GEN0      6'h0A
`define TCB_OFF_BUF0      6'h14
`define TCB_OFF_FUNC      6'h18
`define TCB_OFF_SYNC      6'h19
`define TCB_OFF_MODE      6'h1A
`define TCB_OFF_FLAGS     6'h1B

// Counter control register fields.
`define TCB_CTRL_RSVD     7
`define TCB_CTRL_CLR_HI   6
`define TCB_CTRL_CLR_LO   5
`define TCB_CTRL_EDGE_HI  4
`define TCB_CTRL_EDGE_LO  3
`define TCB_CTRL_PSC_HI   2
`define TCB_CTRL_PSC_LO   0

// Function control register: buffer enables.
`define TCB_FUNC_EN_A3    0
`define TCB_FUNC_EN_B3    1
`define TCB_FUNC_EN_A4    2
`define TCB_FUNC_EN_B4    3

// Timer mode register: phase counting on channel 2.
`define TCB_MODE_PHASE    0

// Flag register: flag A of channel i at bit i, flag B at bit 8+i.
`define TCB_FLAG_B_LSB    8

// Reset values.
`define TCB_RST_CTRL      8'h80
`define TCB_RST_BUF       16'hFFFF
`define TCB_RST_GEN       16'hFFFF
`define TCB_RST_CNT       16'h0000

`endif

// *** logic/tcb_pkg.sv ***
// Types shared by the timer clock/clear block files.
package tcb_pkg;

    // One request on the internal register bus; be[1] is the high byte.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } tcb_bus_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
    } tcb_bus_rsp_t;

    // Counter clear source encoding.
    typedef enum logic [1:0] {
        TCB_CLR_NONE,
        TCB_CLR_GEN_A,
        TCB_CLR_GEN_B,
        TCB_CLR_SYNC
    } tcb_clr_t;

endpackage

// *** logic/tcb_ext_edge.sv ***
// Synchroniser and edge detector for the external timer clock inputs.
`timescale 1ns/10ps
module tcb_ext_edge #(
    parameter int N = 4
) (
    input  wire logic         clock_in,
    input  wire logic         nrst_in,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] rise_out,
    output logic      [N-1:0] fall_out
);

    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] last;

    // The first stage feeds only the second; edges are taken after the second.
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            meta <= '0;
            sync <= '0;
            last <= '0;
        end else begin
            meta <= pin_in;
            sync <= meta;
            last <= sync;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rise_out <= '0;
            fall_out <= '0;
        end else begin
            rise_out <= sync & ~last;
            fall_out <= ~sync & last;
        end
    end

endmodule // tcb_ext_edge

// *** logic/tcb_timer.sv ***
// Five-channel timer: clock select, counter clearing, buffered general registers.
//
// Functional notes
// - Four 16-bit buffers: A and B for channels 3 and 4, paired same-letter.
// - Four independent buffer enable bits in the function control register.
// - Compare mode with buffering: match copies buffer into general register.
// - Buffer role follows its general register: compare buffer or capture buffer.
// - Buffers read and written by word or single byte over 16-bit bus.
// - Buffers load all ones on reset and on standby entry.
// - Five identical 8-bit counter control registers, 0x80 on reset and standby.
// - Control bit 7 is read-only, reads one, writes ignored.
// - Clear field: 00 none, 01 general A, 10 general B, 11 synchronous.
// - Clear event is compare match or input capture per general register role.
// - Synchronous clear follows the other channels marked in the sync register.
// - Edge field: 00 rising, 01 falling, 1x both; only for external clocks.
// - Prescaler 000..011 pick clock /1,/2,/4,/8; 100..111 external inputs A..D.
// - Internal clock counts only its falling edges, edge field ignored.
// - External clock counts the edges chosen by the edge field.
// - Channel 2 phase counting ignores prescaler and edge fields.
// - Each counter is 16 bits, counting pulses of the selected clock.
// - Compare match of an output compare register sets its status flag.
`timescale 1ns/10ps
`include "tcb_defs.svh"
module tcb_timer #(
    parameter int NCH = 5
) (
    input  wire logic                  clock_in,
    input  wire logic                  nrst_in,
    input  wire logic                  standby_in,
    input  wire tcb_pkg::tcb_bus_req_t bus_req_in,
    output tcb_pkg::tcb_bus_rsp_t      bus_rsp_out,
    input  wire logic [3:0]            ext_clk_in,
    input  wire logic [NCH-1:0]        cap_mode_a_in,
    input  wire logic [NCH-1:0]        cap_mode_b_in,
    input  wire logic [NCH-1:0]        cap_evt_a_in,
    input  wire logic [NCH-1:0]        cap_evt_b_in,
    input  wire logic                  phase_up_in,
    input  wire logic                  phase_dn_in,
    output logic [NCH-1:0][15:0]       counter_out,
    output logic [NCH-1:0]             flag_a_out,
    output logic [NCH-1:0]             flag_b_out
);

    logic                  init;
    logic [NCH-1:0][7:0]   ctrl;
    logic [NCH-1:0][15:0]  cnt;
    logic [NCH-1:0][15:0]  general_reg_a;
    logic [NCH-1:0][15:0]  general_reg_b;
    logic [3:0][15:0]      buff;
    logic [3:0]            func;
    logic [NCH-1:0]        sync_sel;
    logic                  phase_en;
    logic [2:0]            presc;
    logic [3:0]            ext_rise;
    logic [3:0]            ext_fall;
    logic [NCH-1:0]        eq_a_q;
    logic [NCH-1:0]        eq_b_q;
    logic [NCH-1:0]        match_a;
    logic [NCH-1:0]        match_b;
    logic [NCH-1:0]        ev_a;
    logic [NCH-1:0]        ev_b;
    logic [NCH-1:0]        own_clr;
    logic [NCH-1:0]        clr;
    logic [NCH-1:0]        tick;
    logic                  sync_hit;

    // Standby returns every register except those in u_edge (reset by nrst_in only) to its reset value, like a reset.
    assign init = !nrst_in || standby_in;

    function automatic logic wr_at(input tcb_pkg::tcb_bus_req_t r, input logic [5:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // Merge a word or single-byte write into a 16-bit register.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input tcb_pkg::tcb_bus_req_t r);
        logic [15:0] v;
        v = old;
        if (r.be[0]) begin
            v[7:0] = r.wdata[7:0];
        end
        if (r.be[1]) begin
            v[15:8] = r.wdata[15:8];
        end
        return v;
    endfunction

    // Counting pulse chosen by the prescaler and edge fields.
    function automatic logic clk_pulse(input logic [7:0] c, input logic [2:0] p,
                                       input logic [3:0] re, input logic [3:0] fe);
        logic r;
        logic f;
        r = re[c[1:0]];
        f = fe[c[1:0]];
        if (!c[`TCB_CTRL_PSC_HI]) begin
            // Falling edge of the divided clock is the cycle its divider wraps.
            case (c[1:0])
                2'b00:   clk_pulse = 1'b1;
                2'b01:   clk_pulse = p[0];
                2'b10:   clk_pulse = &p[1:0];
                default: clk_pulse = &p;
            endcase
        end else if (c[`TCB_CTRL_EDGE_HI]) begin
            clk_pulse = r | f;
        end else if (c[`TCB_CTRL_EDGE_LO]) begin
            clk_pulse = f;
        end else begin
            clk_pulse = r;
        end
    endfunction

    tcb_ext_edge #(
        .N(4)
    ) u_edge (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .pin_in   (ext_clk_in),
        .rise_out (ext_rise),
        .fall_out (ext_fall)
    );

    // Free-running divider for the internal clock taps.
    always_ff @(posedge clock_in) begin
        if (init) begin
            presc <= 3'h0;
        end else begin
            presc <= presc + 3'h1;
        end
    end

    // Compare match is taken on the cycle the counter first equals the register.
    always_ff @(posedge clock_in) begin
        if (init) begin
            eq_a_q <= '0;
            eq_b_q <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                eq_a_q[i] <= (cnt[i] == general_reg_a[i]);
                eq_b_q[i] <= (cnt[i] == general_reg_b[i]);
            end
        end
    end

    always_comb begin
        sync_hit = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            match_a[i] = (cnt[i] == general_reg_a[i]) && !eq_a_q[i] && !cap_mode_a_in[i];
            match_b[i] = (cnt[i] == general_reg_b[i]) && !eq_b_q[i] && !cap_mode_b_in[i];
            ev_a[i] = cap_mode_a_in[i] ? cap_evt_a_in[i] : match_a[i];
            ev_b[i] = cap_mode_b_in[i] ? cap_evt_b_in[i] : match_b[i];
            case (tcb_pkg::tcb_clr_t'(ctrl[i][`TCB_CTRL_CLR_HI:`TCB_CTRL_CLR_LO]))
                tcb_pkg::TCB_CLR_GEN_A: own_clr[i] = ev_a[i];
                tcb_pkg::TCB_CLR_GEN_B: own_clr[i] = ev_b[i];
                default:                own_clr[i] = 1'b0;
            endcase
            if (sync_sel[i] && own_clr[i]) begin
                sync_hit = 1'b1;
            end
            tick[i] = clk_pulse(ctrl[i], presc, ext_rise, ext_fall);
        end
        for (int i = 0; i < NCH; i++) begin
            // A synchronised channel with sync clear follows its group's clears.
            clr[i] = own_clr[i] || (sync_hit && sync_sel[i] &&
                     (ctrl[i][`TCB_CTRL_CLR_HI:`TCB_CTRL_CLR_LO] == 2'b11));
        end
    end

    // Counter control registers; bit 7 is forced high on every write.
    always_ff @(posedge clock_in) begin
        for (int i = 0; i < NCH; i++) begin
            if (init) begin
                ctrl[i] <= `TCB_RST_CTRL;
            end else if (wr_at(bus_req_in, `TCB_OFF_CTRL0 + 6'(i)) && bus_req_in.be[0]) begin
                ctrl[i] <= {1'b1, bus_req_in.wdata[6:0]};
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (init) begin
            func     <= 4'h0;
            sync_sel <= '0;
            phase_en <= 1'b0;
        end else begin
            if (wr_at(bus_req_in, `TCB_OFF_FUNC) && bus_req_in.be[0]) begin
                func <= bus_req_in.wdata[3:0];
            end
            if (wr_at(bus_req_in, `TCB_OFF_SYNC) && bus_req_in.be[0]) begin
                sync_sel <= bus_req_in.wdata[NCH-1:0];
            end
            if (wr_at(bus_req_in, `TCB_OFF_MODE) && bus_req_in.be[0]) begin
                phase_en <= bus_req_in.wdata[`TCB_MODE_PHASE];
            end
        end
    end

    // Counters: a bus write wins over a clear, and a clear over a count.
    always_ff @(posedge clock_in) begin
        for (int i = 0; i < NCH; i++) begin
            if (init) begin
                cnt[i] <= `TCB_RST_CNT;
            end else if (wr_at(bus_req_in, `TCB_OFF_CNT0 + 6'(i))) begin
                cnt[i] <= merge(cnt[i], bus_req_in);
            end else if (clr[i]) begin
                cnt[i] <= 16'h0000;
            end else if (i == 2 && phase_en) begin
                // Phase counting owns channel 2; its clock fields have no say.
                if (phase_up_in && !phase_dn_in) begin
                    cnt[i] <= cnt[i] + 16'h0001;
                end else if (phase_dn_in && !phase_up_in) begin
                    cnt[i] <= cnt[i] - 16'h0001;
                end
            end else if (tick[i]) begin
                cnt[i] <= cnt[i] + 16'h0001;
            end
        end
    end

    // General registers: bus write, then capture, then buffer transfer on match.
    always_ff @(posedge clock_in) begin
        for (int i = 0; i < NCH; i++) begin
            if (init) begin
                general_reg_a[i] <= `TCB_RST_GEN;
                general_reg_b[i] <= `TCB_RST_GEN;
            end else begin
                if (wr_at(bus_req_in, `TCB_OFF_GEN0 + 6'(2 * i))) begin
                    general_reg_a[i] <= merge(general_reg_a[i], bus_req_in);
                end else if (cap_mode_a_in[i] && cap_evt_a_in[i]) begin
                    general_reg_a[i] <= cnt[i];
                end else if (i >= 3 && match_a[i] && func[2 * ((i + 1) % 2)]) begin
                    general_reg_a[i] <= buff[2 * ((i + 1) % 2)];
                end
                if (wr_at(bus_req_in, `TCB_OFF_GEN0 + 6'(2 * i + 1))) begin
                    general_reg_b[i] <= merge(general_reg_b[i], bus_req_in);
                end else if (cap_mode_b_in[i] && cap_evt_b_in[i]) begin
                    general_reg_b[i] <= cnt[i];
                end else if (i >= 3 && match_b[i] && func[2 * ((i + 1) % 2) + 1]) begin
                    general_reg_b[i] <= buff[2 * ((i + 1) % 2) + 1];
                end
            end
        end
    end

    // Buffers: index 0/1 pair with A/B of channel 3, 2/3 with A/B of channel 4.
    always_ff @(posedge clock_in) begin
        for (int k = 0; k < 4; k++) begin
            if (init) begin
                buff[k] <= `TCB_RST_BUF;
            end else if (wr_at(bus_req_in, `TCB_OFF_BUF0 + 6'(k))) begin
                buff[k] <= merge(buff[k], bus_req_in);
            end else if (func[k]) begin
                // In capture role the buffer keeps the previous capture.
                if ((k % 2 == 0) && cap_mode_a_in[3 + k / 2] && cap_evt_a_in[3 + k / 2]) begin
                    buff[k] <= general_reg_a[3 + k / 2];
                end else if ((k % 2 == 1) && cap_mode_b_in[3 + k / 2]
                             && cap_evt_b_in[3 + k / 2]) begin
                    buff[k] <= general_reg_b[3 + k / 2];
                end
            end
        end
    end

    // Status flags: writing 0 clears, but an event in the same cycle wins.
    always_ff @(posedge clock_in) begin
        for (int i = 0; i < NCH; i++) begin
            if (init) begin
                flag_a_out[i] <= 1'b0;
                flag_b_out[i] <= 1'b0;
            end else begin
                if (ev_a[i]) begin
                    flag_a_out[i] <= 1'b1;
                end else if (wr_at(bus_req_in, `TCB_OFF_FLAGS) && bus_req_in.be[0]
                             && !bus_req_in.wdata[i]) begin
                    flag_a_out[i] <= 1'b0;
                end
                if (ev_b[i]) begin
                    flag_b_out[i] <= 1'b1;
                end else if (wr_at(bus_req_in, `TCB_OFF_FLAGS) && bus_req_in.be[1]
                             && !bus_req_in.wdata[`TCB_FLAG_B_LSB + i]) begin
                    flag_b_out[i] <= 1'b0;
                end
            end
        end
    end

    // Read data is registered: it appears the cycle after the read strobe.
    always_ff @(posedge clock_in) begin
        if (init) begin
            bus_rsp_out <= '0;
        end else begin
            bus_rsp_out.valid <= bus_req_in.rd;
            bus_rsp_out.rdata <= 16'h0000;
            if (bus_req_in.rd) begin
                for (int i = 0; i < NCH; i++) begin
                    if (bus_req_in.addr == `TCB_OFF_CTRL0 + 6'(i)) begin
                        bus_rsp_out.rdata <= {8'h00, ctrl[i]};
                    end
                    if (bus_req_in.addr == `TCB_OFF_CNT0 + 6'(i)) begin
                        bus_rsp_out.rdata <= cnt[i];
                    end
                    if (bus_req_in.addr == `TCB_OFF_GEN0 + 6'(2 * i)) begin
                        bus_rsp_out.rdata <= general_reg_a[i];
                    end
                    if (bus_req_in.addr == `TCB_OFF_GEN0 + 6'(2 * i + 1)) begin
                        bus_rsp_out.rdata <= general_reg_b[i];
                    end
                end
                for (int k = 0; k < 4; k++) begin
                    if (bus_req_in.addr == `TCB_OFF_BUF0 + 6'(k)) begin
                        bus_rsp_out.rdata <= buff[k];
                    end
                end
                case (bus_req_in.addr)
                    `TCB_OFF_FUNC:  bus_rsp_out.rdata <= {12'h000, func};
                    `TCB_OFF_SYNC:  bus_rsp_out.rdata <= 16'(sync_sel);
                    `TCB_OFF_MODE:  bus_rsp_out.rdata <= {15'h0000, phase_en};
                    `TCB_OFF_FLAGS: bus_rsp_out.rdata <= {3'h0, flag_b_out, 3'h0, flag_a_out};
                    default:        ;
                endcase
            end
        end
    end

    assign counter_out = cnt;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    chk_ctrl_top_one: assert property (ctrl[1][7] && ctrl[3][7])
        else $error("control register top bit is not one");
    chk_standby_buf: assert property (standby_in
        |=> buff[0] == 16'hFFFF && buff[3] == 16'hFFFF)
        else $error("buffer not all ones after standby");
    chk_standby_ctrl: assert property (standby_in
        |=> ctrl[0] == 8'h80 && ctrl[4] == 8'h80)
        else $error("control register not 0x80 after standby");
    chk_buf_copy_gen: assert property (match_b[4] && func[3]
        && !bus_req_in.wr && !standby_in |=> general_reg_b[4] == $past(buff[3]))
        else $error("buffer not copied on compare match");
    chk_capture_shift: assert property (cap_mode_a_in[3] && cap_evt_a_in[3] && func[0]
        && !bus_req_in.wr && !standby_in
        |=> buff[0] == $past(general_reg_a[3]) && general_reg_a[3] == $past(cnt[3]))
        else $error("capture did not shift general register into buffer");
    chk_clear_gen_a: assert property (ctrl[1][6:5] == 2'b01 && ev_a[1] && !bus_req_in.wr
        && !standby_in |=> cnt[1] == 16'h0000)
        else $error("counter not cleared by general register A event");
    chk_div8_hold: assert property (ctrl[0][2:0] == 3'b011 && presc != 3'h7
        && !clr[0] && !bus_req_in.wr && !standby_in |=> $stable(cnt[0]))
        else $error("divide-by-8 counter moved off its falling edge");
    chk_ext_rise: assert property (ctrl[0][4:0] == 5'b00100 && ext_rise[0] && !clr[0]
        && !bus_req_in.wr && !standby_in |=> cnt[0] == $past(cnt[0]) + 16'h0001)
        else $error("external rising edge not counted");
    chk_phase_own: assert property (phase_en && !phase_up_in && !phase_dn_in && !clr[2]
        && !bus_req_in.wr && !standby_in ##0 tick[2] |=> $stable(cnt[2]))
        else $error("channel 2 counted its clock in phase mode");
    chk_flag_set: assert property (match_b[4] && !standby_in |=> flag_b_out[4])
        else $error("compare match flag not set");

    cov_buf_copy:   cover property (match_b[4] && func[3]);
    cov_capture:    cover property (cap_evt_a_in[3] && cap_mode_a_in[3] && func[0]);
    cov_phase_up:   cover property (phase_en && phase_up_in && !phase_dn_in);
    cov_sync_clear: cover property (sync_hit && ctrl[2][6:5] == 2'b11 && sync_sel[2]);

endmodule // tcb_timer

// *** bench/tcb_clk_src.sv ***
// Model of the external timer clock pins: bursts of pulses on one selected pin.
`timescale 1ns/10ps
module tcb_clk_src (
    input  wire logic       clock_in,
    input  wire logic       go_in,
    input  wire logic [1:0] sel_in,
    output logic      [3:0] pin_out,
    output logic            busy_out
);
    logic [4:0] step = 5'h18;

    assign busy_out = (step < 5'h18);
    // Each level lasts four cycles so the two-stage synchroniser sees every edge.
    // Three rising and three falling edges per burst; pins sit low outside a burst.
    assign pin_out = busy_out ? ({3'b000, ~step[2]} << sel_in) : 4'h0;

    always_ff @(posedge clock_in) begin
        if (go_in && !busy_out) begin
            step <= 5'h00;
        end else if (busy_out) begin
            step <= step + 5'h01;
        end
    end
endmodule // tcb_clk_src

// *** bench/tb_top.sv ***
// Self-checking bench for the timer clock, clear and buffer block.
`timescale 1ns/10ps
module tb_top;
    logic                  clk = 1'b0;
    logic                  nrst = 1'b0;
    logic                  stby = 1'b0;
    tcb_pkg::tcb_bus_req_t req = '0;
    tcb_pkg::tcb_bus_rsp_t rsp;
    logic [3:0]            pins;
    logic                  go = 1'b0;
    logic [1:0]            sel = 2'h0;
    logic                  src_busy;
    logic [4:0]            evt = 5'h00;
    logic                  pu = 1'b0;
    logic                  pd = 1'b0;
    logic [4:0][15:0]      cnt;
    logic [4:0]            fla;
    logic [4:0]            flb;
    logic [15:0]           exq[$];
    int                    n_fail = 0;
    int                    comparisons = 0;
    int                    seed = 86545;
    logic [15:0]           v, h, a, mx;

    always #25 clk = ~clk;

    tcb_timer #(.NCH(5)) i_tcb_timer (
        .clock_in      (clk),
        .nrst_in       (nrst),
        .standby_in    (stby),
        .bus_req_in    (req),
        .bus_rsp_out   (rsp),
        .ext_clk_in    (pins),
        .cap_mode_a_in (5'h08),
        .cap_mode_b_in (5'h00),
        .cap_evt_a_in  (evt),
        .cap_evt_b_in  (5'h00),
        .phase_up_in   (pu),
        .phase_dn_in   (pd),
        .counter_out   (cnt),
        .flag_a_out    (fla),
        .flag_b_out    (flb)
    );

    tcb_clk_src i_tcb_clk_src (
        .clock_in (clk),
        .go_in    (go),
        .sel_in   (sel),
        .pin_out  (pins),
        .busy_out (src_busy)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] ad, input logic [1:0] be, input logic [15:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, ad, be, d};
        @(posedge clk);
        req <= '0;
    endtask

    // The expected word is queued at the request; the monitor pairs it with the reply.
    task automatic rd(input logic [5:0] ad, input logic [15:0] e);
        @(posedge clk);
        req <= '{1'b0, 1'b1, ad, 2'h3, 16'h0000};
        exq.push_back(e);
        @(posedge clk);
        req <= '0;
    endtask

    task automatic complete_run;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (rsp.valid === 1'b1) begin
            chk(rsp.rdata, exq.pop_front());
        end
    end

    initial begin
        #250000;
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) rd(6'h14 + 6'(i), 16'hFFFF);
        for (int i = 0; i < 5; i++) rd(6'(i), 16'h0080);
        rd(6'h3F, 16'h0000);
        $display("reset values done");
        for (int i = 0; i < 5; i++) begin
            v = 16'($random(seed));
            wr(6'(i), 2'h1, v);
            rd(6'(i), {8'h00, 1'b1, v[6:0]});
        end
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            h = 16'($random(seed));
            wr(6'h14 + 6'(i), 2'h3, v);
            wr(6'h14 + 6'(i), 2'h2, h);
            rd(6'h14 + 6'(i), {h[15:8], v[7:0]});
        end
        @(posedge clk);
        stby <= 1'b1;
        @(posedge clk);
        stby <= 1'b0;
        rd(6'h15, 16'hFFFF);
        rd(6'h03, 16'h0080);
        $display("register access done");
        // The divider runs free, so any 16-cycle window holds 16/div counts.
        for (int d = 0; d < 4; d++) begin
            v = 16'($random(seed));
            wr(6'h00, 2'h1, {11'h000, v[1:0], 1'b0, 2'(d)});
            @(negedge clk);
            a = cnt[0];
            repeat (16) @(negedge clk);
            chk(cnt[0] - a, 16'h0010 >> d);
        end
        $display("internal prescaler done");
        for (int p = 0; p < 4; p++) begin
            wr(6'h00, 2'h1, {11'h000, 2'(p), 1'b1, 2'(p)});
            sel <= 2'(p);
            repeat (6) @(negedge clk);
            a = cnt[0];
            @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (36) @(negedge clk);
            chk(cnt[0] - a, (p > 1) ? 16'h0006 : 16'h0003);
        end
        $display("external clock done");
        wr(6'h0C, 2'h3, 16'h0010);
        wr(6'h01, 2'h1, 16'h0020);
        // Channel 2 joins channel 1 in the sync group and clears only with it.
        wr(6'h19, 2'h1, 16'h0006);
        wr(6'h02, 2'h1, 16'h0060);
        wr(6'h06, 2'h3, 16'h0000);
        wr(6'h07, 2'h3, 16'h0000);
        mx = 16'h0000;
        h = 16'h0000;
        repeat (60) begin
            @(negedge clk);
            if (cnt[1] > mx) mx = cnt[1];
            if (cnt[2] > h) h = cnt[2];
        end
        chk(mx, 16'h0010);
        chk(h, 16'h0010);
        chk({15'h0000, fla[1]}, 16'h0001);
        $display("compare clear done");
        wr(6'h18, 2'h1, 16'h0009);
        wr(6'h13, 2'h3, 16'h0020);
        wr(6'h17, 2'h3, 16'h1234);
        wr(6'h12, 2'h3, 16'h0008);
        wr(6'h16, 2'h3, 16'h5555);
        wr(6'h09, 2'h3, 16'h0000);
        repeat (50) @(posedge clk);
        rd(6'h13, 16'h1234);
        rd(6'h12, 16'h0008);
        chk({15'h0000, flb[4]}, 16'h0001);
        $display("compare buffer done");
        v = 16'($random(seed));
        wr(6'h10, 2'h3, v);
        @(posedge clk);
        evt <= 5'h08;
        @(negedge clk);
        a = cnt[3];
        @(posedge clk);
        evt <= 5'h00;
        rd(6'h10, a);
        rd(6'h14, v);
        $display("capture buffer done");
        // Phase mode: one both-high pulse, four up and one down; the /1 clock is ignored.
        wr(6'h02, 2'h1, 16'h0000);
        wr(6'h1A, 2'h1, 16'h0001);
        wr(6'h07, 2'h3, 16'h0100);
        @(posedge clk);
        {pu, pd} <= 2'b11;
        @(posedge clk);
        {pu, pd} <= 2'b10;
        repeat (4) @(posedge clk);
        {pu, pd} <= 2'b01;
        @(posedge clk);
        {pu, pd} <= 2'b00;
        @(negedge clk);
        chk(cnt[2], 16'h0103);
        $display("phase count done");
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule // tb_top
